// ==== inc/sfs_regs.svh ====
// Opcodes, address masks and timing figures of the flash command sequencer.
`ifndef SFS_REGS_SVH
`define SFS_REGS_SVH
`define SFS_OP_PP 8'h02
`define SFS_OP_PP2 8'ha2
`define SFS_OP_PP4 8'h32
`define SFS_OP_PE_A 8'h81
`define SFS_OP_PE_B 8'hdb
`define SFS_OP_BE4 8'h20
`define SFS_OP_BE32 8'h52
`define SFS_HDR_BYTES 10'h004
`define SFS_CNT_MAX 10'h3ff
`define SFS_MASK_PAGE 24'h0000ff
`define SFS_MASK_4K 24'h000fff
`define SFS_MASK_32K 24'h007fff
`define SFS_MEM_BYTES 19'h40000
`define SFS_SECT_BYTES 19'h01000
`define SFS_PROT_ALL 4'h7
`define SFS_ERASED 8'hff
`define SFS_CLK_NS 20
`define SFS_PROG_US 1000
`define SFS_PERASE_US 4000
`define SFS_SECT_US 4000
`define SFS_MID_US 8000
`define SFS_SCK_HALF 2'h2
`define SFS_CS_GAP 4'h8
`endif

// ==== inc/sfs_pkg.sv ====
// Types shared by both ends of the flash command link.
package sfs_pkg;
  typedef enum logic [1:0] {SFS_LANE1 = 2'h0, SFS_LANE2 = 2'h1, SFS_LANE4 = 2'h2} sfs_lane_type;
  typedef enum logic [2:0] {
    SFS_K_NONE = 3'h0, SFS_K_PROG = 3'h1, SFS_K_PERASE = 3'h2, SFS_K_E4 = 3'h3, SFS_K_E32 = 3'h4
  } sfs_kind_type;
  typedef enum logic [1:0] {SFS_S_IDLE = 2'h0, SFS_S_RUN = 2'h1, SFS_S_END = 2'h3} sfs_state_type;
endpackage : sfs_pkg

// ==== inc/sfs_link_if.sv ====
// Serial link between the host controller and the flash sequencer.
`timescale 1ns/100ps
`default_nettype none
interface sfs_link_if;
  logic cs_n;
  logic sck;
  logic [3:0] h_io_o;
  logic [3:0] h_io_oe;
  logic [3:0] d_io_o;
  logic [3:0] d_io_oe;
  logic [3:0] io;
  // Undriven lines float high through the board pull-ups.
  assign io = (h_io_oe & h_io_o) | (~h_io_oe & d_io_oe & d_io_o) | (~h_io_oe & ~d_io_oe);
  modport host (output cs_n, output sck, output h_io_o, output h_io_oe, input io);
  modport device (input cs_n, input sck, input io, output d_io_o, output d_io_oe);
endinterface : sfs_link_if
`default_nettype wire

// ==== hw/sfs_shift.sv ====
// Byte deserialiser for one, two or four data lines, sampled on the link clock.
`timescale 1ns/100ps
`default_nettype none
module sfs_shift
  import sfs_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_restart,
  input wire sfs_lane_type i_lanes,
  input wire logic [3:0] i_io,
  output logic [7:0] o_byte,
  output logic o_done,
  output logic o_mid
);
  logic [7:0] acc_q;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic [3:0] base;

  always_comb begin
    base = i_restart ? 4'h0 : cnt_q;
    unique case (i_lanes)
      SFS_LANE2: begin
        o_byte = {acc_q[5:0], i_io[1:0]};
        cnt_d = base + 4'h2;
      end
      SFS_LANE4: begin
        o_byte = {acc_q[3:0], i_io[3:0]};
        cnt_d = base + 4'h4;
      end
      default: begin
        o_byte = {acc_q[6:0], i_io[0]};
        cnt_d = base + 4'h1;
      end
    endcase
  end

  assign o_done = cnt_d[3];
  assign o_mid = (cnt_q != 4'h0);

  always_ff @(posedge i_clk) begin
    acc_q <= o_byte;
    cnt_q <= {1'b0, cnt_d[2:0]};
  end
endmodule : sfs_shift
`default_nettype wire

// ==== hw/sfs_device.sv ====
// Flash end: program and erase sequencing behind the serial link.
// Summary of operation
// RL1 - Single program: opcode, 24-bit address, data bytes.
// RL2 - Program accepted only with write latch set.
// RL3 - Over 256 bytes: last 256 kept.
// RL4 - Short program touches only received bytes.
// RL5 - Select must rise on a byte boundary.
// RL6 - Host keeps select low whole command.
// RL7 - Select rise starts timed program cycle.
// RL8 - Busy flag high during any cycle.
// RL9 - Program completion clears write latch.
// RL10 - Protected page is never programmed.
// RL11 - Dual program: data on two lines.
// RL12 - Quad program needs quad enable set.
// RL13 - Page erase ignores low byte, sets ones.
// RL14 - Host sets write latch before erasing.
// RL15 - Small block erase ignores low twelve bits.
// RL16 - Erase needs exact header, then timed.
// RL17 - Mid block erase needs write latch.
// RL18 - Mid block erase timed, clears latch.
// RL19 - Protected erase region is left untouched.
// RL20 - Host programs only erased locations; neither end checks, so a program writes over stored bytes.
// RL21 - Page erase completes like block erase.
`timescale 1ns/100ps
`default_nettype none
`include "sfs_regs.svh"
module sfs_device
  import sfs_pkg::*;
#(
  parameter int unsigned PROG_CYC = `SFS_PROG_US * 1000 / `SFS_CLK_NS,
  parameter int unsigned PERASE_CYC = `SFS_PERASE_US * 1000 / `SFS_CLK_NS,
  parameter int unsigned SECT_CYC = `SFS_SECT_US * 1000 / `SFS_CLK_NS,
  parameter int unsigned MID_CYC = `SFS_MID_US * 1000 / `SFS_CLK_NS
) (
  input wire logic i_clk,
  input wire logic i_rst,
  sfs_link_if.device lnk,
  input wire logic i_wel_set,
  input wire logic [4:0] i_protect_field,
  input wire logic i_quad_io_enable,
  output logic o_write_enable_latch,
  output logic o_busy_flag,
  output logic o_frame_dropped,
  output logic o_mem_we,
  output logic [17:0] o_mem_addr,
  output logic [7:0] o_mem_data
);
  assign lnk.d_io_o = 4'h0;
  assign lnk.d_io_oe = 4'h0;

  // Link domain. The clock stops outside frames, so the frame start is
  // flagged asynchronously by select and consumed by the first edge.
  logic first_q;
  logic tgl_q;
  logic bsy_s1_q;
  logic bsy_s2_q;
  logic [9:0] byte_cnt_q;
  logic [9:0] idx;
  logic [7:0] opcode_q;
  logic [23:0] addr_q;
  logic [7:0] ptr_q;
  logic [255:0] mask_q;
  logic [7:0] page_q [256];
  sfs_lane_type lanes;
  logic [7:0] rx_byte;
  logic rx_done;
  logic rx_mid;
  logic is_prog;
  logic data_wr;

  always_ff @(posedge lnk.sck or posedge lnk.cs_n) begin
    if (lnk.cs_n) begin
      first_q <= 1'b1;
    end else begin
      first_q <= 1'b0;
    end
  end

  always_ff @(posedge lnk.sck or posedge i_rst) begin
    if (i_rst) begin
      tgl_q <= 1'b0;
    end else if (first_q) begin
      tgl_q <= ~tgl_q;
    end
  end

  always_ff @(posedge lnk.sck) begin
    bsy_s1_q <= o_busy_flag;
    bsy_s2_q <= bsy_s1_q;
  end

  assign idx = first_q ? 10'h000 : byte_cnt_q;
  assign is_prog = (opcode_q == `SFS_OP_PP) || (opcode_q == `SFS_OP_PP2) ||
                   (opcode_q == `SFS_OP_PP4);

  always_comb begin
    lanes = SFS_LANE1;
    if (!first_q && byte_cnt_q >= `SFS_HDR_BYTES) begin
      if (opcode_q == `SFS_OP_PP2) begin
        lanes = SFS_LANE2; // RL11
      end else if (opcode_q == `SFS_OP_PP4) begin
        lanes = SFS_LANE4; // RL12
      end
    end
  end

  sfs_shift u_shift (
    .i_clk(lnk.sck),
    .i_restart(first_q),
    .i_lanes(lanes),
    .i_io(lnk.io),
    .o_byte(rx_byte),
    .o_done(rx_done),
    .o_mid(rx_mid)
  );

  always_ff @(posedge lnk.sck) begin
    if (first_q) begin
      byte_cnt_q <= {9'h000, rx_done};
    end else if (rx_done && byte_cnt_q != `SFS_CNT_MAX) begin
      byte_cnt_q <= byte_cnt_q + 10'h001;
    end
  end

  always_ff @(posedge lnk.sck) begin
    if (rx_done && idx == 10'h000) begin
      opcode_q <= rx_byte; // RL1
    end
    if (rx_done && idx != 10'h000 && idx < `SFS_HDR_BYTES) begin
      addr_q <= {addr_q[15:0], rx_byte}; // RL1
    end
  end

  // Buffer writes are held off while a cycle is reading the buffer.
  assign data_wr = rx_done && idx >= `SFS_HDR_BYTES && is_prog && !bsy_s2_q;

  always_ff @(posedge lnk.sck) begin
    if (rx_done && idx == `SFS_HDR_BYTES - 10'h001) begin
      ptr_q <= rx_byte;
    end else if (data_wr) begin
      ptr_q <= ptr_q + 8'h01; // RL3
    end
  end

  // The mask is cleared only while the synchronised busy is low, so a
  // frame sent during a cycle cannot wipe the offsets still being written.
  always_ff @(posedge lnk.sck) begin
    if (rx_done && idx == `SFS_HDR_BYTES - 10'h001 && !bsy_s2_q) begin
      mask_q <= '0;
    end else if (data_wr) begin
      mask_q[ptr_q] <= 1'b1; // RL4
    end
  end

  always_ff @(posedge lnk.sck) begin
    if (data_wr) begin
      page_q[ptr_q] <= rx_byte; // RL3
    end
  end

  // Clock domain. Link state is frozen while select is high, so it is read
  // directly once the synchronised select has risen.
  logic cs_s1_q;
  logic cs_s2_q;
  logic cs_s3_q;
  logic tgl_s1_q;
  logic tgl_s2_q;
  logic seen_q;
  logic cs_rise;
  sfs_kind_type kind;
  logic [23:0] span;
  logic [18:0] lo;
  logic [18:0] hi;
  logic [18:0] psize;
  logic prot;
  logic len_ok;
  logic accept;
  logic finish;
  sfs_state_type state_q;
  sfs_kind_type kind_q;
  logic [23:0] base_q;
  logic [15:0] last_q;
  logic [15:0] walk_q;
  logic [23:0] timer_q;

  always_ff @(posedge i_clk) begin
    cs_s1_q <= lnk.cs_n;
    cs_s2_q <= cs_s1_q;
    cs_s3_q <= cs_s2_q;
    tgl_s1_q <= tgl_q;
    tgl_s2_q <= tgl_s1_q;
  end

  assign cs_rise = cs_s2_q && !cs_s3_q && (tgl_s2_q != seen_q);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      seen_q <= 1'b0;
    end else if (cs_s2_q && !cs_s3_q) begin
      seen_q <= tgl_s2_q;
    end
  end

  always_comb begin
    unique case (opcode_q)
      `SFS_OP_PP, `SFS_OP_PP2, `SFS_OP_PP4: kind = SFS_K_PROG;
      `SFS_OP_PE_A, `SFS_OP_PE_B: kind = SFS_K_PERASE; // RL13
      `SFS_OP_BE4: kind = SFS_K_E4; // RL15
      `SFS_OP_BE32: kind = SFS_K_E32; // RL17
      default: kind = SFS_K_NONE;
    endcase
    unique case (kind)
      SFS_K_E4: span = `SFS_MASK_4K; // RL15
      SFS_K_E32: span = `SFS_MASK_32K; // RL17
      default: span = `SFS_MASK_PAGE; // RL13
    endcase
  end

  always_comb begin
    lo = {1'b0, addr_q[17:0] & ~span[17:0]};
    hi = lo | {1'b0, span[17:0]};
    if (i_protect_field[3:0] == 4'h0) begin
      psize = 19'h00000;
    end else if (i_protect_field[3:0] >= `SFS_PROT_ALL) begin
      psize = `SFS_MEM_BYTES;
    end else begin
      psize = `SFS_SECT_BYTES << (i_protect_field[3:0] - 4'h1);
    end
    if (psize == 19'h00000) begin
      prot = 1'b0;
    end else if (i_protect_field[4]) begin
      prot = lo < psize;
    end else begin
      prot = hi >= `SFS_MEM_BYTES - psize;
    end
  end

  assign len_ok = (kind == SFS_K_PROG) ? (byte_cnt_q > `SFS_HDR_BYTES)
                                       : (byte_cnt_q == `SFS_HDR_BYTES); // RL16 RL21
  assign accept = cs_rise && state_q == SFS_S_IDLE && kind != SFS_K_NONE && len_ok &&
                  !rx_mid && // RL5
                  o_write_enable_latch && // RL2 RL14 RL17
                  (opcode_q != `SFS_OP_PP4 || i_quad_io_enable) && // RL12
                  !prot; // RL10 RL19
  assign finish = state_q == SFS_S_END && timer_q == 24'h000000;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_q <= SFS_S_IDLE;
    end else begin
      unique case (state_q)
        SFS_S_IDLE: if (accept) state_q <= SFS_S_RUN;
        SFS_S_RUN: if (walk_q == last_q) state_q <= SFS_S_END;
        SFS_S_END: if (finish) state_q <= SFS_S_IDLE;
        default: state_q <= SFS_S_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      kind_q <= SFS_K_NONE;
      base_q <= 24'h000000;
      last_q <= 16'h0000;
      walk_q <= 16'h0000;
    end else if (accept) begin
      kind_q <= kind;
      base_q <= addr_q & ~span;
      last_q <= span[15:0];
      walk_q <= 16'h0000;
    end else if (state_q == SFS_S_RUN) begin
      walk_q <= walk_q + 16'h0001;
    end
  end

  // The programmed or erased bytes are written first; the busy time is
  // counted from the select rise, so it must exceed the walk length.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      timer_q <= 24'h000000;
    end else if (accept) begin
      unique case (kind)
        SFS_K_PROG: timer_q <= 24'(PROG_CYC); // RL7
        SFS_K_PERASE: timer_q <= 24'(PERASE_CYC); // RL21
        SFS_K_E4: timer_q <= 24'(SECT_CYC); // RL16
        default: timer_q <= 24'(MID_CYC); // RL18
      endcase
    end else if (timer_q != 24'h000000) begin
      timer_q <= timer_q - 24'h000001;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_busy_flag <= 1'b0;
    end else if (accept) begin
      o_busy_flag <= 1'b1; // RL8
    end else if (finish) begin
      o_busy_flag <= 1'b0; // RL8
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_write_enable_latch <= 1'b0;
    end else if (i_wel_set) begin
      o_write_enable_latch <= 1'b1;
    end else if (finish) begin
      o_write_enable_latch <= 1'b0; // RL9 RL18 RL21
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_frame_dropped <= 1'b0;
    end else begin
      o_frame_dropped <= cs_rise && !accept;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_mem_we <= 1'b0;
      o_mem_addr <= 18'h00000;
      o_mem_data <= 8'h00;
    end else begin
      o_mem_we <= state_q == SFS_S_RUN && (kind_q != SFS_K_PROG || mask_q[walk_q[7:0]]); // RL4
      o_mem_addr <= base_q[17:0] + {2'h0, walk_q};
      o_mem_data <= (kind_q == SFS_K_PROG) ? page_q[walk_q[7:0]] : `SFS_ERASED; // RL13 RL15
    end
  end
endmodule : sfs_device
`default_nettype wire

// ==== hw/sfs_host.sv ====
// Host end: sends program and erase frames and makes the link clock.
`timescale 1ns/100ps
`default_nettype none
`include "sfs_regs.svh"
module sfs_host
  import sfs_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  sfs_link_if.host lnk,
  input wire logic i_cmd_valid,
  input wire logic [7:0] i_cmd_opcode,
  input wire logic [23:0] i_cmd_addr,
  input wire logic [9:0] i_cmd_len,
  input wire logic [7:0] i_data,
  output logic o_cmd_ready,
  output logic o_data_take,
  output logic o_done
);
  sfs_state_type state_q;
  logic [1:0] div_q;
  logic sck_q;
  logic cs_n_q;
  logic [7:0] sr_q;
  logic [3:0] bits_q;
  logic [9:0] byte_q;
  logic [9:0] last_q;
  logic [7:0] op_q;
  logic [23:0] addr_q;
  logic [3:0] gap_q;
  sfs_lane_type lanes_q;
  logic tick;
  logic fall;
  logic byte_end;
  logic [3:0] step;

  assign tick = div_q == `SFS_SCK_HALF - 2'h1;
  assign fall = state_q == SFS_S_RUN && tick && sck_q;
  assign step = (lanes_q == SFS_LANE4) ? 4'h4 : (lanes_q == SFS_LANE2) ? 4'h2 : 4'h1;
  assign byte_end = fall && (bits_q + step == 4'h8);
  assign o_cmd_ready = state_q == SFS_S_IDLE;
  assign o_data_take = byte_end && byte_q != last_q && byte_q + 10'h001 >= `SFS_HDR_BYTES;
  assign lnk.cs_n = cs_n_q;
  assign lnk.sck = sck_q;

  always_comb begin
    unique case (lanes_q)
      SFS_LANE2: begin
        lnk.h_io_o = {2'h0, sr_q[7:6]}; // RL11
        lnk.h_io_oe = {2'h0, {2{!cs_n_q}}};
      end
      SFS_LANE4: begin
        lnk.h_io_o = sr_q[7:4]; // RL12
        lnk.h_io_oe = {4{!cs_n_q}};
      end
      default: begin
        lnk.h_io_o = {3'h0, sr_q[7]}; // RL1
        lnk.h_io_oe = {3'h0, !cs_n_q};
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_q <= SFS_S_IDLE;
    end else begin
      unique case (state_q)
        SFS_S_IDLE: if (i_cmd_valid) state_q <= SFS_S_RUN;
        SFS_S_RUN: if (byte_end && byte_q == last_q) state_q <= SFS_S_END;
        SFS_S_END: if (gap_q == `SFS_CS_GAP) state_q <= SFS_S_IDLE;
        default: state_q <= SFS_S_IDLE;
      endcase
    end
  end

  // Select stays low from acceptance until the last byte's final fall.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cs_n_q <= 1'b1;
    end else if (state_q == SFS_S_IDLE && i_cmd_valid) begin
      cs_n_q <= 1'b0; // RL6
    end else if (byte_end && byte_q == last_q) begin
      cs_n_q <= 1'b1; // RL5 RL16
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst || state_q != SFS_S_RUN) begin
      div_q <= 2'h0;
      sck_q <= 1'b0;
    end else if (tick) begin
      div_q <= 2'h0;
      sck_q <= !sck_q;
    end else begin
      div_q <= div_q + 2'h1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      gap_q <= 4'h0;
      o_done <= 1'b0;
    end else begin
      gap_q <= (state_q == SFS_S_END) ? gap_q + 4'h1 : 4'h0;
      o_done <= byte_end && byte_q == last_q;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sr_q <= 8'h00;
      bits_q <= 4'h0;
      byte_q <= 10'h000;
      last_q <= 10'h000;
      op_q <= 8'h00;
      addr_q <= 24'h000000;
      lanes_q <= SFS_LANE1;
    end else if (state_q == SFS_S_IDLE && i_cmd_valid) begin
      sr_q <= i_cmd_opcode;
      bits_q <= 4'h0;
      byte_q <= 10'h000;
      last_q <= `SFS_HDR_BYTES - 10'h001 + i_cmd_len;
      op_q <= i_cmd_opcode;
      addr_q <= i_cmd_addr;
      lanes_q <= SFS_LANE1;
    end else if (byte_end) begin
      bits_q <= 4'h0;
      byte_q <= byte_q + 10'h001;
      if (byte_q + 10'h001 < `SFS_HDR_BYTES) begin
        sr_q <= addr_q[23:16]; // RL1
        addr_q <= {addr_q[15:0], 8'h00};
      end else begin
        sr_q <= i_data;
        lanes_q <= (op_q == `SFS_OP_PP2) ? SFS_LANE2 :
                   (op_q == `SFS_OP_PP4) ? SFS_LANE4 : SFS_LANE1; // RL11 RL12
      end
    end else if (fall) begin
      bits_q <= bits_q + step;
      sr_q <= sr_q << step;
    end
  end
endmodule : sfs_host
`default_nettype wire

// ==== bench/sfs_link_asserts.sv ====
// Concurrent checks on the serial link between the host and flash ends.
`timescale 1ns/100ps
`default_nettype none
`include "sfs_regs.svh"
module sfs_link_asserts (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic [3:0] h_io_o,
  input wire logic [3:0] h_io_oe,
  input wire logic [3:0] d_io_oe,
  input wire logic [3:0] io
);
  logic sck_q;
  logic [15:0] bits_q;
  logic [7:0] op_q;
  logic rise;
  logic [3:0] mask;
  assign rise = sck & ~sck_q;
  // The data-phase lane set is decoded from the opcode seen on the wire, not taken from the host.
  assign mask = (op_q == `SFS_OP_PP2) ? 4'h3 : ((op_q == `SFS_OP_PP4) ? 4'hf : 4'h1);
  always_ff @(posedge i_clk) begin
    sck_q <= i_rst ? 1'b0 : sck;
  end
  always_ff @(posedge i_clk) begin
    if (i_rst || cs_n) begin
      bits_q <= 16'h0000;
    end else if (rise) begin
      bits_q <= bits_q + ((bits_q < 16'h0020) ? 16'h0001 :
                16'({mask == 4'hf, mask == 4'h3, mask == 4'h1}));
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      op_q <= 8'h00;
    end else if (rise && bits_q < 16'h0008) begin
      op_q <= {op_q[6:0], io[0]};
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  property p_sck_idle; cs_n |-> !sck; endproperty
  a_sck_idle: assert property (p_sck_idle) else $error("link clock moved outside a frame");
  property p_cs_gap; $rose(cs_n) |-> cs_n [*8]; endproperty
  a_cs_gap: assert property (p_cs_gap) else $error("select gap too short");
  property p_half; $rose(sck) |=> sck ##1 !sck; endproperty
  a_half: assert property (p_half) else $error("link clock high phase wrong");
  property p_setup; $rose(sck) |-> $stable(h_io_o & h_io_oe) && $stable(h_io_oe); endproperty
  a_setup: assert property (p_setup) else $error("data moved at link clock rise");
  property p_hdr_lane; rise && bits_q < 16'h0020 |-> h_io_oe == 4'h1; endproperty
  a_hdr_lane: assert property (p_hdr_lane) else $error("header not on one line");
  property p_data_lane; rise && bits_q >= 16'h0020 |-> h_io_oe == mask; endproperty
  a_data_lane: assert property (p_data_lane) else $error("data lanes wrong for opcode");
  property p_dev_quiet; d_io_oe == 4'h0; endproperty
  a_dev_quiet: assert property (p_dev_quiet) else $error("flash end drove the lines");
  property p_release; cs_n |-> h_io_oe == 4'h0; endproperty
  a_release: assert property (p_release) else $error("host drove lines while deselected");
  property p_byte_end;
    $rose(cs_n) |-> bits_q[2:0] == 3'h0 && bits_q >= 16'h0020 && !sck;
  endproperty
  a_byte_end: assert property (p_byte_end) else $error("select rose off a byte boundary");
endmodule : sfs_link_asserts
`default_nettype wire

// ==== bench/testbench.sv ====
// Self-checking bench joining the host and flash ends over the serial link.
`timescale 1ns/100ps
`default_nettype none
`include "sfs_regs.svh"
module testbench;
  localparam int PROG = 300;
  localparam int PERASE = 300;
  localparam int SECT = 4200;
  localparam int MID = 33000;
  logic i_clk = 1'b0;
  logic i_rst = 1'b0;
  logic i_cmd_valid = 1'b0;
  logic [7:0] i_cmd_opcode = 8'h00;
  logic [23:0] i_cmd_addr = 24'h000000;
  logic [9:0] i_cmd_len = 10'h000;
  logic [7:0] i_data = 8'h01;
  logic i_wel_set = 1'b0;
  logic [4:0] i_protect_field = 5'h00;
  logic i_quad_io_enable = 1'b0;
  logic o_cmd_ready, o_data_take, o_done, o_write_enable_latch, o_busy_flag;
  logic o_frame_dropped, o_mem_we;
  logic [17:0] o_mem_addr;
  logic [7:0] o_mem_data;
  logic [7:0] mem [0:262143];
  int errors = 0;
  int tests_run = 0;
  int wr_cnt = 0;
  sfs_link_if lnk ();
  sfs_host sfs_host_inst (.i_clk(i_clk), .i_rst(i_rst), .lnk(lnk), .i_cmd_valid(i_cmd_valid),
    .i_cmd_opcode(i_cmd_opcode), .i_cmd_addr(i_cmd_addr), .i_cmd_len(i_cmd_len),
    .i_data(i_data), .o_cmd_ready(o_cmd_ready), .o_data_take(o_data_take), .o_done(o_done));
  sfs_device #(.PROG_CYC(PROG), .PERASE_CYC(PERASE), .SECT_CYC(SECT), .MID_CYC(MID))
    sfs_device_inst (.i_clk(i_clk), .i_rst(i_rst), .lnk(lnk), .i_wel_set(i_wel_set),
    .i_protect_field(i_protect_field), .i_quad_io_enable(i_quad_io_enable),
    .o_write_enable_latch(o_write_enable_latch), .o_busy_flag(o_busy_flag),
    .o_frame_dropped(o_frame_dropped), .o_mem_we(o_mem_we), .o_mem_addr(o_mem_addr),
    .o_mem_data(o_mem_data));
  sfs_link_asserts sfs_link_asserts_inst (.i_clk(i_clk), .i_rst(i_rst), .cs_n(lnk.cs_n),
    .sck(lnk.sck), .h_io_o(lnk.h_io_o), .h_io_oe(lnk.h_io_oe), .d_io_oe(lnk.d_io_oe),
    .io(lnk.io));
  always #10 i_clk = ~i_clk;
  // Data bytes follow a maximal-length sequence so that bytes 256 apart differ.
  always @(posedge i_clk) begin
    if (o_data_take) begin
      i_data <= {i_data[6:0], i_data[7] ^ i_data[5] ^ i_data[4] ^ i_data[3]};
    end
    if (o_mem_we) begin
      mem[o_mem_addr] <= o_mem_data;
      wr_cnt <= wr_cnt + 1;
    end
  end
  function automatic logic [7:0] lf(input logic [7:0] v, input int j);
    for (int k = 0; k < j; k++) v = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    return v;
  endfunction : lf
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t %s: got %0h expected %0h", $time, what, got, exp);
    end
  endtask : check
  task automatic stop_test();
    $display("errors %0d checks %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test
  // Sends one frame; a cycle length of 0 skips waiting for the busy period to end.
  task automatic frame(input logic [7:0] op, input logic [23:0] adr, input logic [9:0] len,
      input logic [7:0] base, input logic write_enable_latch, input logic acc, input int cyc, input int nwr);
    int n;
    int w0;
    logic got;
    logic busy_q;
    @(posedge i_clk);
    i_wel_set <= write_enable_latch;
    @(posedge i_clk);
    i_wel_set <= 1'b0;
    i_cmd_valid <= 1'b1;
    i_cmd_opcode <= op;
    i_cmd_addr <= adr;
    i_cmd_len <= len;
    i_data <= base;
    w0 = wr_cnt;
    n = 0;
    do begin
      @(negedge i_clk);
      n++;
    end while (o_cmd_ready !== 1'b1 && n < 100);
    @(posedge i_clk);
    i_cmd_valid <= 1'b0;
    n = 0;
    while (o_done !== 1'b1 && n < 20000) begin
      @(negedge i_clk);
      n++;
    end
    check(o_done, 1'b1, "frame sent");
    got = 1'b0;
    busy_q = o_busy_flag;
    n = 0;
    while (n < 8 && o_frame_dropped !== 1'b1 && !got) begin
      @(negedge i_clk);
      got = (o_busy_flag === 1'b1) && (busy_q !== 1'b1);
      busy_q = o_busy_flag;
      n++;
    end
    check(got, acc, "frame accepted");
    check(o_frame_dropped, !acc, "drop pulse");
    if (got && cyc > 0) begin
      n = 0;
      while (o_busy_flag === 1'b1 && n < cyc + 10) begin
        @(negedge i_clk);
        n++;
      end
      // Busy also stands in the cycle in which the timer reads zero.
      check(n, cyc + 1, "busy length");
      check(o_write_enable_latch, 1'b0, "latch after cycle");
    end
    if (nwr >= 0) check(wr_cnt - w0, nwr, "array writes");
  endtask : frame
  task automatic t_program();
    frame(`SFS_OP_PP, 24'h001230, 10'h003, 8'h41, 1'b1, 1'b1, PROG, 3);
    check(mem[18'h01230], lf(8'h41, 0), "byte 0");
    check(mem[18'h01232], lf(8'h41, 2), "byte 2");
    check(mem[18'h01233], 8'h00, "neighbour");
    frame(`SFS_OP_PP, 24'h001300, 10'h001, 8'h10, 1'b0, 1'b0, 0, 0);
    frame(`SFS_OP_PP, 24'h001300, 10'h000, 8'h10, 1'b1, 1'b0, 0, 0);
  endtask : t_program
  task automatic t_lanes();
    frame(`SFS_OP_PP2, 24'h002000, 10'h004, 8'h80, 1'b1, 1'b1, PROG, 4);
    check(mem[18'h02003], lf(8'h80, 3), "dual byte");
    frame(`SFS_OP_PP4, 24'h002100, 10'h002, 8'h90, 1'b1, 1'b0, 0, 0);
    @(posedge i_clk);
    i_quad_io_enable <= 1'b1;
    frame(`SFS_OP_PP4, 24'h002100, 10'h002, 8'h90, 1'b1, 1'b1, PROG, 2);
    check(mem[18'h02101], lf(8'h90, 1), "quad byte");
  endtask : t_lanes
  task automatic t_overflow();
    frame(`SFS_OP_PP, 24'h004010, 10'h102, 8'h2b, 1'b1, 1'b1, PROG, 256);
    check(mem[18'h04010], lf(8'h2b, 256), "wrapped byte");
    check(mem[18'h04012], lf(8'h2b, 2), "oldest kept");
    check(mem[18'h0400f], lf(8'h2b, 255), "page end");
  endtask : t_overflow
  task automatic t_protect();
    @(posedge i_clk);
    i_protect_field <= 5'h07;
    frame(`SFS_OP_PP, 24'h03f000, 10'h001, 8'h01, 1'b1, 1'b0, 0, 0);
    frame(`SFS_OP_BE4, 24'h010000, 10'h000, 8'h01, 1'b1, 1'b0, 0, 0);
    @(posedge i_clk);
    i_protect_field <= 5'h11;
    frame(`SFS_OP_PP, 24'h000100, 10'h001, 8'h55, 1'b1, 1'b0, 0, 0);
    @(posedge i_clk);
    i_protect_field <= 5'h01;
    frame(`SFS_OP_PP, 24'h000100, 10'h001, 8'h55, 1'b1, 1'b1, PROG, 1);
    @(posedge i_clk);
    i_protect_field <= 5'h00;
    frame(8'hc3, 24'h000000, 10'h000, 8'h01, 1'b1, 1'b0, 0, 0);
  endtask : t_protect
  task automatic t_erase();
    frame(`SFS_OP_PE_A, 24'h001255, 10'h000, 8'h01, 1'b1, 1'b1, PERASE, 256);
    check({mem[18'h01200], mem[18'h012ff]}, 16'hffff, "page erased");
    check({mem[18'h011ff], mem[18'h01300]}, 16'h0000, "page edges");
    frame(`SFS_OP_PP, 24'h001200, 10'h001, 8'h6c, 1'b1, 1'b1, PROG, 1);
    check(mem[18'h01200], 8'h6c, "erased then programmed");
    frame(`SFS_OP_PE_B, 24'h0050ff, 10'h000, 8'h01, 1'b1, 1'b1, PERASE, 256);
    check(mem[18'h05000], 8'hff, "second opcode");
    frame(`SFS_OP_BE4, 24'h002abc, 10'h000, 8'h01, 1'b1, 1'b1, SECT, 4096);
    check({mem[18'h02000], mem[18'h02fff], mem[18'h03000]}, 24'hffff00, "4k block");
    frame(`SFS_OP_BE32, 24'h00abcd, 10'h000, 8'h01, 1'b0, 1'b0, 0, 0);
    frame(`SFS_OP_BE4, 24'h002abc, 10'h001, 8'h01, 1'b1, 1'b0, 0, 0);
    frame(`SFS_OP_BE32, 24'h00abcd, 10'h000, 8'h01, 1'b1, 1'b1, MID, 32768);
    check({mem[18'h08000], mem[18'h0ffff], mem[18'h10000]}, 24'hffff00, "32k block");
  endtask : t_erase
  task automatic t_busy();
    int n;
    frame(`SFS_OP_BE4, 24'h030000, 10'h000, 8'h01, 1'b1, 1'b1, 0, -1);
    frame(`SFS_OP_PP, 24'h031000, 10'h001, 8'h33, 1'b1, 1'b0, 0, -1);
    n = 0;
    while (o_busy_flag === 1'b1 && n < SECT) begin
      @(negedge i_clk);
      n++;
    end
    check({mem[18'h30fff], mem[18'h31000]}, 16'hff00, "busy refusal");
    check(o_busy_flag, 1'b0, "busy end");
  endtask : t_busy
  initial begin
    // A real edge at time zero clears the link-side frame toggle, which has no clock yet.
    i_rst <= 1'b1;
    for (int a = 0; a < 262144; a++) mem[a] = 8'h00;
    repeat (5) @(posedge i_clk);
    i_rst <= 1'b0;
    t_program();
    t_lanes();
    t_overflow();
    t_protect();
    t_erase();
    t_busy();
    stop_test();
  end
  initial begin
    #1800000;
    errors++;
    $display("[ERR] %0t watchdog expired", $time);
    stop_test();
  end
endmodule : testbench
`default_nettype wire
